// ### pkg/fpc_consts.svh
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// Register byte offsets
`define FPC_CTRL_OFS 16'h4000
`define FPC_CTRL_CLR_OFS 16'h4004
`define FPC_CTRL_SET_OFS 16'h4008
`define FPC_CTRL_INV_OFS 16'h400C
`define FPC_ACC_OFS 16'h4010
`define FPC_TAG_OFS 16'h4020
`define FPC_MSK_OFS 16'h4030
`define FPC_W0_OFS 16'h4040
`define FPC_W1_OFS 16'h4050
`define FPC_W2_OFS 16'h4060
`define FPC_W3_OFS 16'h4070
`define FPC_LRU_OFS 16'h4080
`define FPC_HIT_OFS 16'h4090
`define FPC_MIS_OFS 16'h40A0
`define FPC_PFA_OFS 16'h40C0

// Field positions
`define FPC_COH_BIT 16
`define FPC_DATA_LINE_COUNT_LSB 8
`define FPC_PF_LSB 4
`define FPC_WS_LSB 0
`define FPC_WEN_BIT 31
`define FPC_BOOT_BIT 31
`define FPC_TAG_LSB 4
`define FPC_VALID_BIT 3
`define FPC_LOCK_BIT 2
`define FPC_TYPE_BIT 1
`define FPC_MSK_LSB 5
`define FPC_BOOT_ADDR_BIT 25

// Reset values and fixed line numbers
`define FPC_WS_RST 3'h7
`define FPC_MLINE0 4'hA
`define FPC_MLINE1 4'hB

`endif

// ### pkg/fpc_pkg.sv
package fpc_pkg;
    typedef enum logic [2:0] {st_idle, st_resp, st_fill, st_pchk, st_pref} fpc_fsm_t;

    typedef struct packed {
        logic coh;
        logic [1:0] data_line_count;
        logic [1:0] pfsel;
        logic [2:0] ws;
        logic wen;
        logic [3:0] idx;
        logic [15:0][19:0] tag;
        logic [15:0] boot;
        logic [15:0] valid;
        logic [15:0] lock;
        logic [15:0] instr;
        logic [1:0][10:0] tmask;
        logic [31:0] hits;
        logic [31:0] misses;
        logic [31:0] aborts;
        fpc_fsm_t st;
        logic [3:0] fidx;
        logic falloc;
        logic finstr;
        logic fcache;
        logic [2:0] wcnt;
        logic [31:0] faddr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic fready;
        logic [31:0] frdata;
        logic flreq;
    } fpc_core_t;

    typedef struct packed {
        logic [15:0] mru;
    } fpc_plru_t;
endpackage

// ### pkg/fpc_mem_if.sv
`timescale 1ns/1ns
interface fpc_mem_if #(parameter int LINES = 16, parameter int WORDS = 4);
    localparam int IW = $clog2(LINES);
    logic [WORDS-1:0] wr_en;
    logic [IW-1:0] wr_idx;
    logic [WORDS*32-1:0] wr_data;
    logic [IW-1:0] rd_a_idx;
    logic [WORDS*32-1:0] rd_a_data;
    logic [IW-1:0] rd_b_idx;
    logic [WORDS*32-1:0] rd_b_data;
    modport ctl (output wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx, input rd_a_data, rd_b_data);
    modport mem (input wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx, output rd_a_data, rd_b_data);
endinterface

// ### rtl/fpc_data_mem.sv
`timescale 1ns/1ns
module fpc_data_mem #(parameter int LINES = 16, parameter int WORDS = 4)
(
    input wire logic clk,
    input wire logic rst_n,
    fpc_mem_if.mem mp
);
    typedef struct packed {
        logic [LINES-1:0][WORDS*32-1:0] arr;
        logic [WORDS*32-1:0] rd_a;
        logic [WORDS*32-1:0] rd_b;
    } fpc_mem_t;

    fpc_mem_t s_ff;
    fpc_mem_t nxt_s;

    if (LINES < 2 || WORDS < 1)
    begin : g_chk
        $error("fpc_data_mem: unsupported geometry");
    end

    // Per-word write; both read ports registered so reads never see a half write
    always_comb
    begin
        nxt_s = s_ff;
        for (int w = 0; w < WORDS; w++)
        begin
            if (mp.wr_en[w])
                nxt_s.arr[mp.wr_idx][w*32 +: 32] = mp.wr_data[w*32 +: 32];
        end
        nxt_s.rd_a = s_ff.arr[mp.rd_a_idx];
        nxt_s.rd_b = s_ff.arr[mp.rd_b_idx];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign mp.rd_a_data = s_ff.rd_a;
    assign mp.rd_b_data = s_ff.rd_b;
endmodule

// ### rtl/fpc_plru.sv
`timescale 1ns/1ns
module fpc_plru #(parameter int LINES = 16)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [LINES-1:0] cand,
    input wire logic touch,
    input wire logic [$clog2(LINES)-1:0] touch_idx,
    output logic [$clog2(LINES)-1:0] victim,
    output logic found,
    output logic [LINES-1:0] state
);
    import fpc_pkg::*;

    fpc_plru_t s_ff;
    fpc_plru_t nxt_s;
    logic [LINES-1:0] pick;

    if (LINES != 16)
    begin : g_chk
        $error("fpc_plru: state is sized for 16 lines");
    end

    // Bit pseudo-LRU: oldest is the lowest candidate whose recent bit is clear
    always_comb
    begin
        nxt_s = s_ff;
        found = |cand;
        pick = (|(cand & ~s_ff.mru)) ? (cand & ~s_ff.mru) : cand;
        victim = '0;
        for (int i = LINES - 1; i >= 0; i--)
        begin
            if (pick[i])
                victim = ($clog2(LINES))'(i);
        end
        if (touch)
        begin
            nxt_s.mru = s_ff.mru | (LINES'(1) << touch_idx);
            // All marked recent: restart the history from this line alone
            if (&nxt_s.mru)
                nxt_s.mru = LINES'(1) << touch_idx;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign state = s_ff.mru;
endmodule

// ### rtl/fpc_cache.sv
`timescale 1ns/1ns
`include "fpc_consts.svh"

// Operation
// - Sixteen fully associative lockable lines
// - Sixteen-byte lines filled in one access
// - Serve fetches and reads; prefetch when enabled
// - At most four lines hold data
// - Two lines may hit through a mask
// - Victim among unlocked lines by pseudo-LRU
// - Software writes tag, status and words
// - Policy one: program cycle invalidates everything
// - Policy zero: keep locked instruction lines
// - Size field selects zero/one/two/four data lines
// - Changing size field invalidates all lines
// - Prefetch field selects prefetch regions
// - Wait states zero to seven, reset seven
// - Clear, set, invert companions of control
// - Index selects line; enable gates writes
// - Valid lines compare; locked kept; type bit
// - Mask bits force match; lines 10, 11
// - Words unreadable while code-protected
module fpc_cache
    import fpc_pkg::*;
#(
    parameter int LINES = 16,
    parameter int WORDS = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_is_instr,
    input wire logic fetch_cacheable,
    output logic [31:0] fetch_rdata,
    output logic fetch_ready,
    output logic program_flash_req,
    output logic [31:0] program_flash_addr,
    input wire logic [127:0] program_flash_rdata,
    input wire logic program_flash_cycle,
    input wire logic code_protect
);
    fpc_core_t s_ff;
    fpc_core_t nxt_s;
    fpc_mem_if #(.LINES(LINES), .WORDS(WORDS)) mem_if ();

    logic [15:0] req_hits;
    logic [15:0] pf_hits;
    logic [3:0] req_first;
    logic [15:0] data_region;
    logic [15:0] cand;
    logic alloc_instr;
    logic [3:0] victim;
    logic found;
    logic [15:0] lru_state;
    logic touch;
    logic [3:0] touch_idx;
    logic acc;
    logic wr_now;
    logic is_word;
    logic bus_wword;
    logic map_ok;
    logic [31:0] rd_val;
    logic [31:0] ctrl_val;
    logic [31:0] new_ctrl;
    logic fill_done;
    logic mask_line;
    logic pf_go;
    logic [2:0] data_lines;

    if (LINES != 16 || WORDS != 4)
    begin : g_chk
        $error("fpc_cache: line geometry is fixed by the register map");
    end

    // Tag compare of one address against every line
    function automatic logic [15:0] hit_vec(input fpc_core_t s, input logic [31:0] a);
        logic [15:0] h;
        logic [19:0] m;
        h = '0;
        for (int i = 0; i < 16; i++)
        begin
            m = '0;
            if (4'(i) == `FPC_MLINE0)
                m[11:1] = s.tmask[0];
            if (4'(i) == `FPC_MLINE1)
                m[11:1] = s.tmask[1];
            h[i] = s.valid[i] && (s.boot[i] == !a[`FPC_BOOT_ADDR_BIT])
                && (((s.tag[i] ^ a[23:4]) & ~m) == '0);
        end
        return h;
    endfunction

    // Lowest set line wins when more than one matches
    function automatic logic [3:0] first_idx(input logic [15:0] v);
        logic [3:0] r;
        r = '0;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
                r = 4'(i);
        end
        return r;
    endfunction

    fpc_plru #(.LINES(LINES)) u_plru (
        .clk(pclk),
        .rst_n(presetn),
        .cand(cand),
        .touch(touch),
        .touch_idx(touch_idx),
        .victim(victim),
        .found(found),
        .state(lru_state)
    );

    fpc_data_mem #(.LINES(LINES), .WORDS(WORDS)) u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .mp(mem_if.mem)
    );

    // Data lines sit at the top of the array
    assign data_lines = (s_ff.data_line_count == 2'h3) ? 3'h4 : {1'b0, s_ff.data_line_count};
    assign data_region = ~(16'hFFFF >> data_lines);
    assign alloc_instr = (s_ff.st == st_idle) ? fetch_is_instr : 1'b1;
    assign cand = (alloc_instr ? ~data_region : data_region) & ~s_ff.lock;
    assign req_hits = hit_vec(s_ff, fetch_addr);
    assign pf_hits = hit_vec(s_ff, s_ff.faddr);
    assign req_first = first_idx(req_hits);

    // Bus decode helpers
    assign acc = psel && penable;
    assign wr_now = acc && pwrite && s_ff.pready;
    assign is_word = (paddr == `FPC_W0_OFS) || (paddr == `FPC_W1_OFS)
        || (paddr == `FPC_W2_OFS) || (paddr == `FPC_W3_OFS);
    assign bus_wword = wr_now && is_word && s_ff.wen;
    assign mask_line = (s_ff.idx == `FPC_MLINE0) || (s_ff.idx == `FPC_MLINE1);
    assign ctrl_val = {15'h0, s_ff.coh, 6'h0, s_ff.data_line_count, 2'h0, s_ff.pfsel, 1'b0, s_ff.ws};

    // Memory ports: fetch side on port a, register window on port b
    assign mem_if.rd_a_idx = (s_ff.st == st_idle) ? req_first : s_ff.fidx;
    assign mem_if.rd_b_idx = s_ff.idx;

    // Read mux and address map
    always_comb
    begin
        rd_val = '0;
        map_ok = 1'b1;
        if (paddr == `FPC_CTRL_OFS || paddr == `FPC_CTRL_CLR_OFS
            || paddr == `FPC_CTRL_SET_OFS || paddr == `FPC_CTRL_INV_OFS)
            rd_val = ctrl_val;
        else if (paddr == `FPC_ACC_OFS)
            rd_val = {s_ff.wen, 27'h0, s_ff.idx};
        else if (paddr == `FPC_TAG_OFS)
            rd_val = {s_ff.boot[s_ff.idx], 7'h0, s_ff.tag[s_ff.idx], s_ff.valid[s_ff.idx],
                s_ff.lock[s_ff.idx], s_ff.instr[s_ff.idx], 1'b0};
        else if (paddr == `FPC_MSK_OFS)
            rd_val = mask_line ? {16'h0, s_ff.tmask[s_ff.idx[0]], 5'h0} : 32'h0;
        else if (is_word)
            rd_val = code_protect ? 32'h0 : mem_if.rd_b_data[{paddr[5:4], 5'h0} +: 32];
        else if (paddr == `FPC_LRU_OFS)
            rd_val = {16'h0, lru_state};
        else if (paddr == `FPC_HIT_OFS)
            rd_val = s_ff.hits;
        else if (paddr == `FPC_MIS_OFS)
            rd_val = s_ff.misses;
        else if (paddr == `FPC_PFA_OFS)
            rd_val = s_ff.aborts;
        else
            map_ok = 1'b0;
    end

    // Whole next state; invalidations last so they win
    always_comb
    begin
        nxt_s = s_ff;
        touch = 1'b0;
        touch_idx = s_ff.fidx;
        fill_done = 1'b0;
        pf_go = 1'b0;
        new_ctrl = ctrl_val;
        mem_if.wr_en = '0;
        mem_if.wr_idx = s_ff.idx;
        mem_if.wr_data = {WORDS{pwdata}};

        // Ready rises one cycle after penable
        if (acc && !s_ff.pready)
        begin
            nxt_s.pready = 1'b1;
            nxt_s.pslverr = !map_ok;
            nxt_s.prdata = map_ok ? rd_val : 32'h0;
        end
        else if (s_ff.pready)
        begin
            nxt_s.pready = 1'b0;
            nxt_s.pslverr = 1'b0;
        end

        // Fetch engine; ready is a pulse even if a prefetch follows
        nxt_s.fready = 1'b0;
        case (s_ff.st)
            st_idle:
            begin
                if (fetch_req && !s_ff.fready)
                begin
                    nxt_s.faddr = fetch_addr;
                    nxt_s.finstr = fetch_is_instr;
                    nxt_s.fcache = fetch_cacheable;
                    nxt_s.wcnt = '0;
                    if (fetch_cacheable && |req_hits)
                    begin
                        nxt_s.hits = s_ff.hits + 32'h1;
                        nxt_s.fidx = req_first;
                        touch = 1'b1;
                        touch_idx = req_first;
                        nxt_s.st = st_resp;
                    end
                    else
                    begin
                        if (fetch_cacheable)
                            nxt_s.misses = s_ff.misses + 32'h1;
                        nxt_s.falloc = fetch_cacheable && found;
                        nxt_s.fidx = victim;
                        nxt_s.flreq = 1'b1;
                        nxt_s.st = st_fill;
                    end
                end
            end
            st_resp:
            begin
                nxt_s.frdata = mem_if.rd_a_data[{s_ff.faddr[3:2], 5'h0} +: 32];
                nxt_s.fready = 1'b1;
                pf_go = 1'b1;
            end
            st_fill, st_pref:
            begin
                if (s_ff.st == st_pref && fetch_req)
                begin
                    // A demand fetch always beats a speculative one
                    nxt_s.aborts = s_ff.aborts + 32'h1;
                    nxt_s.flreq = 1'b0;
                    nxt_s.st = st_idle;
                end
                else if (s_ff.wcnt != s_ff.ws)
                    nxt_s.wcnt = s_ff.wcnt + 3'h1;
                else if (!bus_wword)
                begin
                    // Fill yields one cycle to a software word write on the same port
                    fill_done = 1'b1;
                    nxt_s.flreq = 1'b0;
                    if (s_ff.falloc)
                    begin
                        mem_if.wr_en = '1;
                        mem_if.wr_idx = s_ff.fidx;
                        mem_if.wr_data = program_flash_rdata;
                        nxt_s.tag[s_ff.fidx] = s_ff.faddr[23:4];
                        nxt_s.boot[s_ff.fidx] = !s_ff.faddr[`FPC_BOOT_ADDR_BIT];
                        nxt_s.valid[s_ff.fidx] = 1'b1;
                        nxt_s.lock[s_ff.fidx] = 1'b0;
                        nxt_s.instr[s_ff.fidx] = s_ff.finstr;
                        touch = 1'b1;
                    end
                    if (s_ff.st == st_fill)
                    begin
                        nxt_s.frdata = program_flash_rdata[{s_ff.faddr[3:2], 5'h0} +: 32];
                        nxt_s.fready = 1'b1;
                        pf_go = 1'b1;
                    end
                    else
                        nxt_s.st = st_idle;
                end
            end
            st_pchk:
            begin
                // Skip held lines; give up when nothing may be replaced
                if (|pf_hits || !found)
                    nxt_s.st = st_idle;
                else
                begin
                    nxt_s.fidx = victim;
                    nxt_s.falloc = 1'b1;
                    nxt_s.finstr = 1'b1;
                    nxt_s.wcnt = '0;
                    nxt_s.flreq = 1'b1;
                    nxt_s.st = st_pref;
                end
            end
            default:
                nxt_s.st = st_idle;
        endcase

        // Next-line prefetch after an instruction answer
        if (pf_go)
        begin
            if (s_ff.finstr && ((s_ff.fcache && s_ff.pfsel[0])
                || (!s_ff.fcache && s_ff.pfsel[1])))
            begin
                nxt_s.faddr = {s_ff.faddr[31:4] + 28'h1, 4'h0};
                nxt_s.st = st_pchk;
            end
            else
                nxt_s.st = st_idle;
        end

        // Register writes land at the edge pready is seen high
        if (wr_now && map_ok)
        begin
            if (paddr == `FPC_CTRL_OFS)
                new_ctrl = pwdata;
            else if (paddr == `FPC_CTRL_CLR_OFS)
                new_ctrl = ctrl_val & ~pwdata;
            else if (paddr == `FPC_CTRL_SET_OFS)
                new_ctrl = ctrl_val | pwdata;
            else if (paddr == `FPC_CTRL_INV_OFS)
                new_ctrl = ctrl_val ^ pwdata;
            else if (paddr == `FPC_ACC_OFS)
            begin
                nxt_s.wen = pwdata[`FPC_WEN_BIT];
                nxt_s.idx = pwdata[3:0];
            end
            else if (paddr == `FPC_TAG_OFS && s_ff.wen)
            begin
                nxt_s.boot[s_ff.idx] = pwdata[`FPC_BOOT_BIT];
                nxt_s.tag[s_ff.idx] = pwdata[`FPC_TAG_LSB +: 20];
                nxt_s.valid[s_ff.idx] = pwdata[`FPC_VALID_BIT];
                nxt_s.lock[s_ff.idx] = pwdata[`FPC_LOCK_BIT];
                nxt_s.instr[s_ff.idx] = pwdata[`FPC_TYPE_BIT];
            end
            else if (paddr == `FPC_MSK_OFS && s_ff.wen && mask_line)
                nxt_s.tmask[s_ff.idx[0]] = pwdata[`FPC_MSK_LSB +: 11];
            else if (bus_wword)
            begin
                mem_if.wr_en = 4'h1 << paddr[5:4];
                mem_if.wr_idx = s_ff.idx;
            end
            else if (paddr == `FPC_HIT_OFS)
                nxt_s.hits = pwdata;
            else if (paddr == `FPC_MIS_OFS)
                nxt_s.misses = pwdata;
            else if (paddr == `FPC_PFA_OFS)
                nxt_s.aborts = pwdata;
            nxt_s.coh = new_ctrl[`FPC_COH_BIT];
            nxt_s.data_line_count = new_ctrl[`FPC_DATA_LINE_COUNT_LSB +: 2];
            nxt_s.pfsel = new_ctrl[`FPC_PF_LSB +: 2];
            nxt_s.ws = new_ctrl[`FPC_WS_LSB +: 3];
        end

        // Invalidations, applied last; a fill finishing now is dropped too
        if (nxt_s.data_line_count != s_ff.data_line_count)
            nxt_s.valid = '0;
        if (program_flash_cycle)
        begin
            if (s_ff.coh)
                nxt_s.valid = '0;
            else
                nxt_s.valid = nxt_s.valid & nxt_s.lock & nxt_s.instr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '{ws: `FPC_WS_RST, instr: '1, st: st_idle, default: '0};
        end
        else
            s_ff <= nxt_s;
    end

    // Outputs straight from the state register
    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign fetch_rdata = s_ff.frdata;
    assign fetch_ready = s_ff.fready;
    assign program_flash_req = s_ff.flreq;
    assign program_flash_addr = {s_ff.faddr[31:4], 4'h0};
endmodule

// ### tb/fpc_flash_model.sv
`timescale 1ns/1ns
module fpc_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic program_flash_req,
    input wire logic [31:0] program_flash_addr,
    output logic [127:0] program_flash_rdata,
    output int acc_count
);
    logic req_q;

    // Whole line per access; idle shows the inverse so stale data looks wrong
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            program_flash_rdata[32*k +: 32] = {program_flash_addr[31:4], k[1:0], 2'b00}
                ^ (program_flash_req ? 32'h5A5A_0000 : 32'hA5A5_FFFF);
    end

    // Count accesses to prove a hit leaves flash alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q <= 1'b0;
            acc_count <= 0;
        end
        else
        begin
            req_q <= program_flash_req;
            if (program_flash_req && !req_q)
                acc_count <= acc_count + 1;
        end
    end
endmodule

// ### tb/fpc_cache_sva.sv
`timescale 1ns/1ns
module fpc_cache_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fetch_req,
    input wire logic fetch_ready,
    input wire logic program_flash_req,
    input wire logic [31:0] program_flash_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    chk_rdata_hold: assert property (!pready |-> $stable(prdata))
        else $error("prdata moved");
    chk_fill_align: assert property (program_flash_req |-> program_flash_addr[3:0] == 4'h0)
        else $error("fill not aligned");
    chk_fill_hold: assert property (program_flash_req && $past(program_flash_req)
        |-> $stable(program_flash_addr)) else $error("fill address moved");
    chk_fill_len: assert property ($rose(program_flash_req) |-> ##[1:8] !program_flash_req)
        else $error("fill too long");
    chk_fetch_bound: assert property (fetch_req && !fetch_ready |-> ##[1:24] fetch_ready)
        else $error("fetch not answered");
endmodule

bind fpc_cache fpc_cache_sva fpc_cache_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_req(fetch_req), .fetch_ready(fetch_ready), .program_flash_req(program_flash_req),
    .program_flash_addr(program_flash_addr));

// ### tb/tb.sv
`timescale 1ns/1ns
`include "fpc_consts.svh"
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic fetch_req = 1'b0, fetch_is_instr = 1'b1, fetch_cacheable = 1'b1, program_flash_req;
    logic program_flash_cycle = 1'b0, code_protect = 1'b0, pready, pslverr, fetch_ready, err;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, fetch_addr = 32'h0, prdata, fetch_rdata, program_flash_addr, rd;
    logic [127:0] program_flash_rdata;
    int err_total = 0, num_checks = 0, acc_count, lat, lm, a0;

    // 10 MHz system clock
    always #50 pclk = ~pclk;

    fpc_cache fpc_cache_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_is_instr(fetch_is_instr), .fetch_cacheable(fetch_cacheable),
        .fetch_rdata(fetch_rdata), .fetch_ready(fetch_ready),
        .program_flash_req(program_flash_req), .program_flash_addr(program_flash_addr),
        .program_flash_rdata(program_flash_rdata), .program_flash_cycle(program_flash_cycle),
        .code_protect(code_protect));
    fpc_flash_model fpc_flash_model_i (.pclk(pclk), .presetn(presetn),
        .program_flash_req(program_flash_req), .program_flash_addr(program_flash_addr),
        .program_flash_rdata(program_flash_rdata), .acc_count(acc_count));

    task finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Spent wait fails the run
    task tmo(input logic hit);
        if (hit)
        begin
            err_total++;
            finish_test();
        end
    endtask

    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 9 && pready !== 1'b1; i++)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(i == 9);
    endtask

    // Request held to the answer; lat counts edges
    task fetch(input logic [31:0] a, input logic ins);
        @(posedge pclk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        fetch_is_instr <= ins;
        for (lat = 0; lat < 40 && fetch_ready !== 1'b1; lat++)
            @(posedge pclk);
        rd = fetch_rdata;
        fetch_req <= 1'b0;
        tmo(lat == 40);
    endtask

    task tagv(input logic [3:0] i, input logic [31:0] v);
        apb(1'b1, `FPC_ACC_OFS, {1'b1, 27'h0, i});
        apb(1'b0, `FPC_TAG_OFS, '0);
        chk("line valid", {31'h0, rd[3]}, v);
    endtask

    task pcyc();
        @(posedge pclk);
        program_flash_cycle <= 1'b1;
        @(posedge pclk);
        program_flash_cycle <= 1'b0;
    endtask

    task t_regs();
        apb(1'b0, `FPC_CTRL_OFS, '0);
        chk("ctrl reset", rd, 32'h0000_0007);
        apb(1'b1, `FPC_CTRL_SET_OFS, '1);
        apb(1'b0, `FPC_CTRL_OFS, '0);
        chk("ctrl set", rd, 32'h0001_0337);
        apb(1'b1, `FPC_CTRL_CLR_OFS, 32'h0001_0230);
        apb(1'b1, `FPC_CTRL_INV_OFS, 32'h0000_0005);
        apb(1'b0, `FPC_CTRL_OFS, '0);
        chk("ctrl clr inv", rd, 32'h0000_0102);
        apb(1'b0, 16'h40B0, '0);
        chk("unmapped err", {31'h0, err}, 32'h1);
    endtask

    // Each wait state costs a miss one edge; a fetch cuts a prefetch
    task t_ws();
        logic [31:0] a;
        for (int w = 0; w < 8; w++)
        begin
            a = 32'h0200_1004 + 32'(w * 16);
            apb(1'b1, `FPC_CTRL_OFS, 32'(w));
            fetch(a, 1'b1);
            chk("fill data", rd, {a[31:2], 2'b00} ^ 32'h5A5A_0000);
            lm = lat;
            a0 = acc_count;
            fetch(a, 1'b1);
            chk("hit data", rd, {a[31:2], 2'b00} ^ 32'h5A5A_0000);
            chk("hit flash", 32'(acc_count - a0), '0);
            chk("wait states", 32'(lm - lat), 32'(w));
        end
        apb(1'b0, `FPC_HIT_OFS, '0);
        chk("hit count", rd, 32'h8);
        apb(1'b0, `FPC_MIS_OFS, '0);
        chk("miss count", rd, 32'h8);
        apb(1'b1, `FPC_CTRL_OFS, 32'h12);
        fetch(32'h0200_3000, 1'b1);
        fetch(32'h0200_3010, 1'b1);
        apb(1'b0, `FPC_PFA_OFS, '0);
        chk("pf aborts", rd, 32'h1);
    endtask

    // Each size code: a reread refetches only with size code zero (no data lines)
    task t_dsz();
        for (int d = 0; d < 4; d++)
        begin
            apb(1'b1, `FPC_CTRL_OFS, 32'(d << 8));
            fetch(32'h0200_2008, 1'b0);
            a0 = acc_count;
            fetch(32'h0200_2008, 1'b0);
            chk("data refetch", 32'(acc_count - a0), (d == 0) ? 32'h1 : 32'h0);
        end
    endtask

    // Software-built lines: readback, gate, protection, hits
    task t_sw();
        apb(1'b1, `FPC_CTRL_OFS, '0);
        apb(1'b1, `FPC_ACC_OFS, 32'h8000_0003);
        apb(1'b1, `FPC_TAG_OFS, 32'h0000_010E);
        for (int k = 0; k < 4; k++)
            apb(1'b1, 16'(`FPC_W0_OFS + 16 * k), 32'hC0DE_0000 + 32'(k));
        apb(1'b0, `FPC_TAG_OFS, '0);
        chk("tag readback", rd, 32'h0000_010E);
        apb(1'b1, `FPC_ACC_OFS, 32'h0000_0003);
        apb(1'b1, `FPC_W1_OFS, '0);
        code_protect <= 1'b1;
        apb(1'b0, `FPC_W1_OFS, '0);
        chk("protected word", rd, '0);
        code_protect <= 1'b0;
        apb(1'b0, `FPC_W1_OFS, '0);
        chk("gated word", rd, 32'hC0DE_0001);
        a0 = acc_count;
        fetch(32'h0200_0104, 1'b1);
        chk("sw line hit", rd, 32'hC0DE_0001);
        apb(1'b1, `FPC_ACC_OFS, 32'h8000_000B);
        apb(1'b1, `FPC_TAG_OFS, 32'h0000_020A);
        apb(1'b1, `FPC_W2_OFS, 32'hAAAA_5555);
        apb(1'b1, `FPC_MSK_OFS, 32'h0000_0020);
        fetch(32'h0200_0228, 1'b1);
        chk("mask hit", rd, 32'hAAAA_5555);
        chk("hits no flash", 32'(acc_count - a0), '0);
        apb(1'b1, `FPC_ACC_OFS, 32'h8000_0003);
        apb(1'b1, `FPC_MSK_OFS, 32'h0000_FFE0);
        apb(1'b1, `FPC_ACC_OFS, 32'h8000_000B);
        apb(1'b0, `FPC_MSK_OFS, '0);
        chk("mask refused", rd, 32'h20);
    endtask

    // Program cycle under both policies, then a size change
    task t_coh();
        pcyc();
        tagv(4'h3, 32'h1);
        tagv(4'hB, 32'h0);
        apb(1'b1, `FPC_CTRL_SET_OFS, 32'h0001_0000);
        pcyc();
        tagv(4'h3, 32'h0);
        apb(1'b1, `FPC_TAG_OFS, 32'h0000_010E);
        apb(1'b1, `FPC_CTRL_SET_OFS, 32'h0000_0100);
        tagv(4'h3, 32'h0);
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ws();
        t_dsz();
        t_sw();
        t_coh();
        finish_test();
    end
endmodule
